// [fts_syndrome.sv]
// Syndrome word builder for trapped floating-point exceptions and system-error interrupts
// Operation
// - Bit 23 flags whether the six floating-point exception flags are valid.
// - Multi-lane traps may clear the valid flag, or report valid flags.
// - Bits 10:8 read all ones for traps from the 32-bit state.
// - Bit 7 reports input-denormal occurrence when flags are valid.
// - Bit 4 reports inexact occurrence when flags are valid.
// - Bit 3 reports underflow occurrence when flags are valid.
// - Bit 2 reports overflow occurrence when flags are valid.
// - Bit 1 reports divide-by-zero occurrence when flags are valid.
// - Bit 0 reports invalid-operation occurrence when flags are valid.
// - A trap is taken only when an occurred exception has its enable set.
// - Bit 24 selects architected or implementation-defined content of bits 23:0.
// - Bit 13 marks implicit-sync errors taken immediately, only for asynchronous code.
// - Bits 12:10 give error state for asynchronous code, else zero.
// - Several errors in one interrupt report the combined overall error state.
// - Bit 9 gives the abort class for asynchronous code, else zero.
// - Software may assume no reset value for any syndrome field.
// - Bits 5:0 hold uncategorized or asynchronous system-error status code.
`timescale 1ns/1ps
module fts_syndrome
    import fts_pkg::*;
#(
    parameter int N_ERR = 4,
    parameter bit HAS_ERR_EXT = 1'b1,
    parameter bit HAS_IMPLICIT_SYNC = 1'b1,
    parameter bit MULTI_LANE_VALID = 1'b0
)
(
    input wire logic ref_clk, // Core clock, 20 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic fp_req_pulse, // One-cycle floating-point exception report
    input fts_fp_req_s fp_req, // Occurred flags and state of the instruction
    input wire logic [FP_EXC_N-1:0] trap_enable, // Enables from the fp control register in use
    input wire logic se_req_pulse, // One-cycle system-error interrupt report
    input fts_se_req_s se_req, // System-error details
    input wire logic [N_ERR-1:0] err_valid, // Errors gathered into this interrupt
    input wire logic [N_ERR*AET_W-1:0] err_state, // Their individual states
    output logic fp_trap_taken, // Combinational: trap accepted this cycle
    output logic [SYN_W-1:0] syndrome_reg, // Last recorded syndrome word
    output fts_kind_e syndrome_kind_reg, // Encoding that the word holds
    output logic syndrome_strobe_reg, // One-cycle pulse when a new word lands
    output logic trap_flags_valid // Registered copy of the fp valid flag
);

    logic fp_hit;
    logic fp_take;
    logic se_take;
    logic flags_valid_w;
    fts_aet_e aet_combined;
    logic [SYN_W-1:0] fp_word_next;
    logic [SYN_W-1:0] se_word_next;
    logic [SYN_W-1:0] syndrome_next;
    fts_kind_e kind_next;
    logic trap_flags_valid_reg;

    // Only exceptions whose own enable is set can raise the trap
    assign fp_hit = fp_req_pulse && ((fp_req.occurred & trap_enable) != '0);

    // The system error wins a same-cycle clash; the fp trap is refused and shown by fp_trap_taken low,
    // so the pipe can replay the instruction rather than lose its report
    assign se_take = se_req_pulse;
    assign fp_take = fp_hit && !se_req_pulse;
    assign fp_trap_taken = fp_take;

    // Multi-lane traps report invalid flags unless the valid-flag option is built in
    assign flags_valid_w = !(fp_req.multi_lane && !MULTI_LANE_VALID);

    // Overall error state when several errors share one interrupt
    fts_aet_combine #(
        .N_ERR(N_ERR)
    ) u_aet_combine (
        .err_valid(err_valid),
        .err_state(err_state),
        .combined(aet_combined)
    );

    // Floating-point trap encoding; invalid flags are driven zero, a legal pick for an unknown value
    always_comb
    begin
        fp_word_next = '0;
        fp_word_next[FP_VALID_BIT] = flags_valid_w;
        // Wide-state value is unknown to software, zero keeps the word deterministic
        fp_word_next[VECTOR_ITERATION_FIELD_HI:VECTOR_ITERATION_FIELD_LO] = fp_req.narrow_state ? VECTOR_ITERATION_FIELD_NARROW_STATE
                                                                : VECTOR_ITERATION_FIELD_WIDE_STATE;
        if (flags_valid_w)
        begin
            fp_word_next[IDF_BIT] = fp_req.occurred[EXC_IDF];
            fp_word_next[IXF_BIT] = fp_req.occurred[EXC_IXF];
            fp_word_next[UFF_BIT] = fp_req.occurred[EXC_UFF];
            fp_word_next[OFF_BIT] = fp_req.occurred[EXC_OFF];
            fp_word_next[DZF_BIT] = fp_req.occurred[EXC_DZF];
            fp_word_next[IOF_BIT] = fp_req.occurred[EXC_IOF];
        end
    end

    // System-error encoding
    always_comb
    begin
        se_word_next = '0;
        if (se_req.impl_syndrome_select)
        begin
            se_word_next[SE_SELECT_BIT] = 1'b1;
            se_word_next[IMPL_W-1:0] = se_req.impl_syndrome;
        end
        else if (HAS_ERR_EXT)
        begin
            se_word_next[FAULT_STATUS_CODE_HI:FAULT_STATUS_CODE_LO] = se_req.async_class ? FAULT_STATUS_CODE_ASYNC_SERROR
                                                                : FAULT_STATUS_CODE_UNCATEGORIZED;
            if (se_req.async_class)
            begin
                se_word_next[SE_IMPLICIT_SYNC_FLAG_BIT] = HAS_IMPLICIT_SYNC && se_req.implicit_sync_taken;
                se_word_next[AET_HI:AET_LO] = aet_combined;
                se_word_next[EA_BIT] = se_req.external_abort_class;
            end
        end
    end

    // Choose the word to record
    always_comb
    begin
        syndrome_next = syndrome_reg;
        kind_next = syndrome_kind_reg;
        if (se_take)
        begin
            syndrome_next = se_word_next;
            kind_next = KIND_SERROR;
        end
        else if (fp_take)
        begin
            syndrome_next = fp_word_next;
            kind_next = KIND_FP;
        end
    end

    // Syndrome word and kind; cleared at reset only so the flops are defined, software must not rely on it
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            syndrome_reg <= SYN_RESET;
            syndrome_kind_reg <= KIND_NONE;
        end
        else
        begin
            syndrome_reg <= syndrome_next;
            syndrome_kind_reg <= kind_next;
        end
    end

    // New-word strobe
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            syndrome_strobe_reg <= 1'b0;
        end
        else
        begin
            syndrome_strobe_reg <= se_take || fp_take;
        end
    end

    // Valid flag mirror, held until the next fp word
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            trap_flags_valid_reg <= 1'b0;
        end
        else if (fp_take)
        begin
            trap_flags_valid_reg <= flags_valid_w;
        end
    end
    assign trap_flags_valid = trap_flags_valid_reg;

    // Checks on the recorded word
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_fp_take;
        fp_req_pulse && !se_req_pulse && ((fp_req.occurred & trap_enable) != '0);
    endsequence

    sequence s_se_arch;
        se_req_pulse && !se_req.impl_syndrome_select && HAS_ERR_EXT;
    endsequence

    sequence s_se_async;
        s_se_arch ##0 se_req.async_class;
    endsequence

    chk_fp_valid_flag: assert property (
        s_fp_take ##0 !fp_req.multi_lane |=> syndrome_reg[FP_VALID_BIT] && trap_flags_valid
            && syndrome_kind_reg == KIND_FP && syndrome_strobe_reg)
        else $error("fp valid flag not set for single-lane trap");

    chk_multi_lane_valid: assert property (
        s_fp_take ##0 fp_req.multi_lane |=> syndrome_reg[FP_VALID_BIT] == MULTI_LANE_VALID)
        else $error("multi-lane valid flag does not follow the build option");

    chk_vector_iteration_field_narrow: assert property (
        s_fp_take ##0 fp_req.narrow_state |=> syndrome_reg[VECTOR_ITERATION_FIELD_HI:VECTOR_ITERATION_FIELD_LO] == 3'h7)
        else $error("vector iteration field not all ones for narrow state");

    chk_fp_flag_copy: assert property (
        s_fp_take ##0 flags_valid_w |=>
            {syndrome_reg[IDF_BIT], syndrome_reg[IXF_BIT:IOF_BIT]} == $past(fp_req.occurred))
        else $error("fp exception flags do not match the occurred exceptions");

    chk_trap_gate: assert property (
        fp_req_pulse && ((fp_req.occurred & trap_enable) == '0) && !se_req_pulse
            |=> !syndrome_strobe_reg && $stable(syndrome_reg))
        else $error("trap taken with no enabled exception");

    chk_impl_select: assert property (
        se_req_pulse && se_req.impl_syndrome_select |=> syndrome_reg[SE_SELECT_BIT]
            && syndrome_reg[IMPL_W-1:0] == $past(se_req.impl_syndrome))
        else $error("implementation syndrome not recorded");

    chk_no_ext_zero: assert property (
        se_req_pulse && !se_req.impl_syndrome_select && !HAS_ERR_EXT |=> syndrome_reg == '0)
        else $error("syndrome not zero without error extension");

    chk_implicit_sync_flag_bit: assert property (
        s_se_arch |=> syndrome_reg[SE_IMPLICIT_SYNC_FLAG_BIT] == ($past(se_req.async_class)
            && $past(se_req.implicit_sync_taken) && HAS_IMPLICIT_SYNC))
        else $error("implicit sync bit wrong");

    chk_aet_field: assert property (
        s_se_async |=> syndrome_reg[AET_HI:AET_LO] == $past(aet_combined))
        else $error("error type field is not the combined state");

    chk_aet_worst: assert property (
        s_se_async ##0 (err_valid[0] && err_state[AET_W-1:0] == 3'b000) |=> syndrome_reg[AET_HI:AET_LO] == 3'b000)
        else $error("uncontainable error not reported as overall state");

    chk_class_zero: assert property (
        s_se_arch ##0 !se_req.async_class |=> syndrome_reg[AET_HI:EA_BIT] == '0)
        else $error("error type or abort class not zero for uncategorized error");

    chk_ea_bit: assert property (
        s_se_async |=> syndrome_reg[EA_BIT] == $past(se_req.external_abort_class))
        else $error("abort class bit wrong");

    chk_status_code: assert property (
        s_se_arch |=> syndrome_reg[FAULT_STATUS_CODE_HI:FAULT_STATUS_CODE_LO] == ($past(se_req.async_class) ? 6'h11 : 6'h00))
        else $error("fault status code wrong");

    chk_reserved_zero: assert property (
        (s_fp_take |=> syndrome_reg[24] == 1'b0 && syndrome_reg[22:11] == '0 && syndrome_reg[6:5] == '0)
        and (s_se_arch |=> syndrome_reg[24:14] == '0 && syndrome_reg[8:6] == '0))
        else $error("reserved syndrome bits not zero");

    chk_strobe_hold: assert property (
        syndrome_strobe_reg ##1 !syndrome_strobe_reg |-> $stable(syndrome_reg))
        else $error("syndrome changed without a strobe");

endmodule // fts_syndrome

// [fts_pkg.sv]
// Package with field layout, codes and carrier types for the trap and system-error syndrome builder
package fts_pkg;

    // Width of the instruction-specific syndrome word
    localparam int SYN_W = 25;
    localparam int FP_EXC_N = 6;
    localparam int AET_W = 3;
    localparam int FAULT_STATUS_CODE_W = 6;
    localparam int IMPL_W = 24;

    // Floating-point trap encoding field positions
    localparam int FP_VALID_BIT = 23;
    localparam int VECTOR_ITERATION_FIELD_HI = 10;
    localparam int VECTOR_ITERATION_FIELD_LO = 8;
    localparam int IDF_BIT = 7;
    localparam int IXF_BIT = 4;
    localparam int UFF_BIT = 3;
    localparam int OFF_BIT = 2;
    localparam int DZF_BIT = 1;
    localparam int IOF_BIT = 0;

    // Index of each exception inside the six-bit occurred and enable vectors
    localparam int EXC_IDF = 5;
    localparam int EXC_IXF = 4;
    localparam int EXC_UFF = 3;
    localparam int EXC_OFF = 2;
    localparam int EXC_DZF = 1;
    localparam int EXC_IOF = 0;

    // System-error encoding field positions
    localparam int SE_SELECT_BIT = 24;
    localparam int SE_IMPLICIT_SYNC_FLAG_BIT = 13;
    localparam int AET_HI = 12;
    localparam int AET_LO = 10;
    localparam int EA_BIT = 9;
    localparam int FAULT_STATUS_CODE_HI = 5;
    localparam int FAULT_STATUS_CODE_LO = 0;

    // Fixed codes
    localparam logic [2:0] VECTOR_ITERATION_FIELD_NARROW_STATE = 3'h7;
    localparam logic [2:0] VECTOR_ITERATION_FIELD_WIDE_STATE = 3'h0;
    localparam logic [FAULT_STATUS_CODE_W-1:0] FAULT_STATUS_CODE_UNCATEGORIZED = 6'h00;
    localparam logic [FAULT_STATUS_CODE_W-1:0] FAULT_STATUS_CODE_ASYNC_SERROR = 6'h11;
    localparam logic [SYN_W-1:0] SYN_RESET = 25'h0000000;

    // Processor error state after the interrupt
    typedef enum logic [2:0] {
        uncontainable_state = 3'b000,
        unrecoverable_state = 3'b001,
        restartable_state = 3'b010,
        recoverable_state = 3'b011,
        corrected_state = 3'b110
    } fts_aet_e;

    // Which encoding the syndrome word holds
    typedef enum logic [1:0] {
        KIND_NONE = 2'b00,
        KIND_FP = 2'b01,
        KIND_SERROR = 2'b10
    } fts_kind_e;

    // Floating-point trap report from the execution pipe
    typedef struct packed {
        logic [FP_EXC_N-1:0] occurred;
        logic narrow_state;
        logic multi_lane;
    } fts_fp_req_s;

    // System-error report from the error-handling logic
    typedef struct packed {
        logic impl_syndrome_select;
        logic [IMPL_W-1:0] impl_syndrome;
        logic async_class;
        logic implicit_sync_taken;
        logic external_abort_class;
    } fts_se_req_s;

endpackage

// [fts_aet_combine.sv]
// Combines the states of several simultaneous errors into the overall processor error state
`timescale 1ns/1ps
module fts_aet_combine
    import fts_pkg::*;
#(
    parameter int N_ERR = 4
)
(
    input wire logic [N_ERR-1:0] err_valid, // One bit per pending error
    input wire logic [N_ERR*AET_W-1:0] err_state, // Packed states, entry i at bits 3i+2:3i
    output fts_aet_e combined // Worst state among valid entries
);

    logic [2:0] rank_w [N_ERR];

    // Severity rank per entry; reserved codes are treated as the worst case
    genvar gi;
    generate
        for (gi = 0; gi < N_ERR; gi++)
        begin : g_rank
            always_comb
            begin
                unique case (err_state[gi*AET_W +: AET_W])
                    3'b000: rank_w[gi] = 3'h5;
                    3'b001: rank_w[gi] = 3'h4;
                    3'b010: rank_w[gi] = 3'h3;
                    3'b011: rank_w[gi] = 3'h2;
                    3'b110: rank_w[gi] = 3'h1;
                    default: rank_w[gi] = 3'h5;
                endcase
                if (!err_valid[gi])
                begin
                    rank_w[gi] = 3'h0;
                end
            end
        end
    endgenerate

    // Pick the highest rank; with nothing pending report uncontainable, the safe reading
    always_comb
    begin
        logic [2:0] best;
        best = 3'h0;
        for (int i = 0; i < N_ERR; i++)
        begin
            if (rank_w[i] > best)
            begin
                best = rank_w[i];
            end
        end
        unique case (best)
            3'h1: combined = corrected_state;
            3'h2: combined = recoverable_state;
            3'h3: combined = restartable_state;
            3'h4: combined = unrecoverable_state;
            default: combined = uncontainable_state;
        endcase
    end

endmodule // fts_aet_combine

// [tb_top.sv]
// Self-checking testbench for the trap and system-error syndrome builder
`timescale 1ns/1ps
module tb_top;
    import fts_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic fp_req_pulse = 1'b0;
    fts_fp_req_s fp_req = '0;
    logic [FP_EXC_N-1:0] trap_enable = '0;
    logic se_req_pulse = 1'b0;
    fts_se_req_s se_req = '0;
    logic [3:0] err_valid = '0;
    logic [11:0] err_state = '0;
    logic fp_trap_taken;
    logic [SYN_W-1:0] syndrome_reg;
    fts_kind_e syndrome_kind_reg;
    logic syndrome_strobe_reg;
    logic trap_flags_valid;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    // Outcome expected at the next falling edge, left by the previous request
    logic e_strobe = 1'b0;
    logic [SYN_W-1:0] e_word = '0;
    fts_kind_e e_kind = KIND_NONE;
    logic e_tfv = 1'b0;

    fts_syndrome dut_u (
        .ref_clk(ref_clk),
        .srst(srst),
        .fp_req_pulse(fp_req_pulse),
        .fp_req(fp_req),
        .trap_enable(trap_enable),
        .se_req_pulse(se_req_pulse),
        .se_req(se_req),
        .err_valid(err_valid),
        .err_state(err_state),
        .fp_trap_taken(fp_trap_taken),
        .syndrome_reg(syndrome_reg),
        .syndrome_kind_reg(syndrome_kind_reg),
        .syndrome_strobe_reg(syndrome_strobe_reg),
        .trap_flags_valid(trap_flags_valid)
    );

    // 20 MHz core clock
    always #25 ref_clk = ~ref_clk;

    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_vec(input logic [SYN_W-1:0] got, input logic [SYN_W-1:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_kind(input fts_kind_e got, input fts_kind_e exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // Expected floating-point word, built bit by bit so a package slip is not copied
    function automatic logic [SYN_W-1:0] fpw(input logic [5:0] occ, input logic narrow, input logic valid);
        fpw = '0;
        fpw[23] = valid;
        if (narrow)
            fpw[10:8] = 3'h7;
        if (valid)
        begin
            fpw[7] = occ[5];
            fpw[4:0] = occ[4:0];
        end
    endfunction

    function automatic logic [SYN_W-1:0] sew(input logic async, input logic sync, input logic [2:0] st, input logic ea);
        sew = '0;
        sew[5:0] = async ? 6'h11 : 6'h00;
        if (async)
        begin
            sew[13] = sync;
            sew[12:10] = st;
            sew[9] = ea;
        end
    endfunction

    // Drive one cycle of requests, check the taken flag now and the previous cycle's word
    task automatic op(input logic fp_p, input fts_fp_req_s f, input logic [5:0] en, input logic se_p,
        input fts_se_req_s s, input logic [3:0] ev, input logic [11:0] es, input logic taken,
        input logic [SYN_W-1:0] w, input fts_kind_e k);
        @(negedge ref_clk);
        fp_req_pulse = fp_p;
        fp_req = f;
        trap_enable = en;
        se_req_pulse = se_p;
        se_req = s;
        err_valid = ev;
        err_state = es;
        #1;
        cmp_bit(fp_trap_taken, taken, "trap taken");
        cmp_bit(syndrome_strobe_reg, e_strobe, "strobe");
        cmp_vec(syndrome_reg, e_word, "word");
        cmp_kind(syndrome_kind_reg, e_kind, "kind");
        cmp_bit(trap_flags_valid, e_tfv, "flags valid");
        e_strobe = taken | se_p;
        if (taken | se_p)
        begin
            e_word = w;
            e_kind = k;
        end
        if (taken & !se_p)
            e_tfv = w[23];
    endtask

    task automatic fp_op(input logic [5:0] occ, input logic nar, input logic ml, input logic [5:0] en,
        input logic taken, input logic [SYN_W-1:0] w);
        op(1'b1, '{occ, nar, ml}, en, 1'b0, '0, 4'h0, 12'h000, taken, w, KIND_FP);
    endtask

    task automatic se_op(input fts_se_req_s s, input logic [3:0] ev, input logic [11:0] es, input logic [SYN_W-1:0] w);
        op(1'b0, '0, 6'h00, 1'b1, s, ev, es, 1'b0, w, KIND_SERROR);
    endtask

    // Quiet cycle: the previous word lands, and the strobe must not linger after it
    task automatic idle();
        op(1'b0, '0, 6'h00, 1'b0, '0, 4'h0, 12'h000, 1'b0, '0, KIND_NONE);
    endtask

    task automatic t_fp_flags();
        fp_op(6'h05, 1'b1, 1'b0, 6'h01, 1'b1, 25'h0800705);
        // Back to back, one exception at a time, in the wide state
        for (int i = 0; i < 6; i++)
            fp_op(6'h01 << i, 1'b0, 1'b0, 6'h01 << i, 1'b1, fpw(6'h01 << i, 1'b0, 1'b1));
        fp_op(6'h3F, 1'b0, 1'b0, 6'h20, 1'b1, fpw(6'h3F, 1'b0, 1'b1));
        idle();
    endtask

    task automatic t_fp_refuse();
        fp_op(6'h3E, 1'b1, 1'b0, 6'h01, 1'b0, '0);
        fp_op(6'h00, 1'b0, 1'b0, 6'h3F, 1'b0, '0);
        idle();
    endtask

    task automatic t_fp_multi();
        fp_op(6'h0C, 1'b1, 1'b1, 6'h0C, 1'b1, fpw(6'h0C, 1'b1, 1'b0));
        fp_op(6'h02, 1'b0, 1'b0, 6'h02, 1'b1, fpw(6'h02, 1'b0, 1'b1));
        idle();
    endtask

    task automatic t_se();
        logic [2:0] codes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b110};
        // Implementation word present but not selected, so it must not leak
        se_op('{1'b0, 24'hFFFFFF, 1'b1, 1'b1, 1'b1}, 4'h3, 12'h00B, 25'h0002611);
        foreach (codes[i])
            se_op('{1'b0, 24'h0, 1'b1, 1'b0, 1'b0}, 4'h4, {3'h0, codes[i], 6'h00}, sew(1'b1, 1'b0, codes[i], 1'b0));
        se_op('{1'b0, 24'h0, 1'b1, 1'b0, 1'b0}, 4'h9, 12'h606, sew(1'b1, 1'b0, 3'b011, 1'b0));
        se_op('{1'b0, 24'h0, 1'b1, 1'b0, 1'b0}, 4'hF, 12'hC9E, sew(1'b1, 1'b0, 3'b010, 1'b0));
        se_op('{1'b0, 24'h123456, 1'b0, 1'b1, 1'b1}, 4'hF, 12'h000, 25'h0000000);
        se_op('{1'b1, 24'hA5C3F0, 1'b1, 1'b1, 1'b1}, 4'h1, 12'h001, 25'h1A5C3F0);
        idle();
    endtask

    // A system error in the same cycle wins and the floating-point report is refused
    task automatic t_clash();
        op(1'b1, '{6'h01, 1'b0, 1'b0}, 6'h01, 1'b1, '{1'b0, 24'h0, 1'b1, 1'b0, 1'b1}, 4'h1, 12'h001,
            1'b0, sew(1'b1, 1'b0, 3'b001, 1'b1), KIND_SERROR);
        idle();
    endtask

    // Mid-run reset clears the word to the chosen deterministic value
    task automatic t_reset();
        fp_op(6'h01, 1'b1, 1'b0, 6'h01, 1'b1, fpw(6'h01, 1'b1, 1'b1));
        @(negedge ref_clk);
        srst = 1'b1;
        fp_req_pulse = 1'b0;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        e_strobe = 1'b0;
        e_word = '0;
        e_kind = KIND_NONE;
        e_tfv = 1'b0;
        idle();
    endtask

    initial
    begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        idle();
        t_fp_flags();
        t_fp_refuse();
        t_fp_multi();
        t_se();
        t_clash();
        t_reset();
        finish_test();
    end
endmodule // tb_top
